// [hw/vcs_pkg.sv]
/*
  Constants for the valve current setpoint shaper: register map, field
  layouts, reset values and timing counts.
  Assumes a 100 MHz core clock and a plain one-cycle register port.
*/
`default_nettype none
package vcs_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  // Start-up hold, shortest allowed time
  localparam int unsigned STARTUP_MS   = 270;
  localparam int unsigned STARTUP_CYC  = (CLK_HZ / 1000) * STARTUP_MS;
  // Dither frequency range and default
  localparam int unsigned DITH_MIN_HZ  = 130;
  localparam int unsigned DITH_MAX_HZ  = 488;
  localparam int unsigned DITH_DEF_HZ  = 195;
  // Sample rate of the processing chain
  localparam int unsigned SAMPLE_HZ    = 10_000;
  localparam int unsigned SAMPLE_CYC   = CLK_HZ / SAMPLE_HZ;
  // Half-period count of the dither square wave
  localparam logic [19:0] DITH_DEF_HALF = 20'(CLK_HZ / (2 * DITH_DEF_HZ));
  localparam logic [19:0] DITH_MIN_HALF = 20'(CLK_HZ / (2 * DITH_MAX_HZ));
  localparam logic [19:0] DITH_MAX_HALF = 20'(CLK_HZ / (2 * DITH_MIN_HZ));
  // Written half period counts steps of eight cycles, so 16 bits reach 130 Hz
  localparam int unsigned DITH_UNIT_SH  = 3;

  localparam int unsigned AW = 5;
  localparam int unsigned DW = 16;
  // Register word addresses
  localparam logic [4:0] A_CTRL      = 5'h00;
  localparam logic [4:0] A_POS_GAIN  = 5'h01;
  localparam logic [4:0] A_NEG_GAIN  = 5'h02;
  localparam logic [4:0] A_POS_BIAS  = 5'h03;
  localparam logic [4:0] A_NEG_BIAS  = 5'h04;
  localparam logic [4:0] A_THRESH    = 5'h05;
  localparam logic [4:0] A_OFFSET    = 5'h06;
  localparam logic [4:0] A_RAMP0     = 5'h07; // four rates, 07..0A
  localparam logic [4:0] A_DITH_HALF = 5'h0B;
  localparam logic [4:0] A_DITH_AMP  = 5'h0C;
  localparam logic [4:0] A_FB_REF    = 5'h0D;
  localparam logic [4:0] A_STATUS    = 5'h0E;
  localparam logic [4:0] A_CMD       = 5'h0F;
  localparam logic [4:0] A_LIN0      = 5'h10; // eight knee points, 10..17
  localparam int unsigned LIN_N      = 8;
  // Control fields
  localparam int unsigned C_SRC      = 0;  // 1 = fieldbus reference
  localparam int unsigned C_LOOP     = 1;  // 1 = current-loop input
  localparam int unsigned C_BRK_EN   = 2;  // cable break detection
  localparam int unsigned C_RMP_LO   = 3;  // ramp mode, 2 bits
  localparam int unsigned C_LIN_EN   = 5;
  localparam logic [15:0] CTRL_RST   = 16'h0006; // loop input, break on, ramp off
  // Default gain is unity in Q4.12
  localparam logic [15:0] GAIN_RST   = 16'h1000;
  localparam int unsigned GAIN_SH    = 12;
  localparam logic [15:0] RAMP_RST   = 16'h0010;
  localparam logic [15:0] DAMP_RST   = 16'h0100;

  typedef enum logic [1:0] {
    VCS_RAMP_OFF  = 2'b00,
    VCS_RAMP_ONE  = 2'b01,
    VCS_RAMP_TWO  = 2'b10,
    VCS_RAMP_FOUR = 2'b11
  } vcs_ramp_t;
endpackage
`default_nettype wire

// [hw/vcs_shaper.sv]
/*
  Setpoint shaper: threshold-gated bias, sign gain, offset, linearization,
  ramp, dither, enable gating and fault output.
  Assumes enable and fault pins come from outside and are synchronised here;
  the register port is on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Enable low forces current command off
// - Fault output low while fault present
// - Short, open coil, loop break fault
// - Fault independent of enable input
// - Gain maps full reference to max
// - Separate gains for positive, negative reference
// - Bias added for analog or fieldbus
// - Bias only above threshold magnitude
// - Sign selects positive or negative bias
// - Offset current added at zero reference
// - Ramp turns steps into gradual change
// - Three ramp modes: one, two, four
// - Ramp disableable, off after reset
// - Programmable piecewise linearization mapping
// - Dither 130 to 488 Hz, default 195
// - Current held zero during start-up
// - Reference source analog or fieldbus
// - Loop input default with break detection
module vcs_shaper #(
  parameter int unsigned STARTUP_CYCLES = vcs_pkg::STARTUP_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [15:0] i_analog_ref,
  input  wire logic        i_enable,
  input  wire logic        i_coil_short,
  input  wire logic        i_coil_open,
  input  wire logic        i_loop_low,
  output logic      [15:0] o_current_cmd,
  output logic             o_fault_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and status registers, shared wires
  logic [15:0] ctrl_r, pgain_r, ngain_r, pbias_r, nbias_r, thr_r, off_r;
  logic [15:0] ramp_r [4];
  logic [15:0] lin_r [vcs_pkg::LIN_N];
  logic [19:0] dhalf_r;
  logic [15:0] damp_r, fbref_r;
  logic        fault_r, ready_r;
  logic signed [15:0] cmd_r;
  logic        en_s;
  logic [19:0] dith_w;

  // Address decode shared by the write and read ports
  function automatic logic is_lin(input logic [4:0] a);
    return (a >= vcs_pkg::A_LIN0) && (int'(a) < int'(vcs_pkg::A_LIN0) + vcs_pkg::LIN_N);
  endfunction
  function automatic logic is_ramp(input logic [4:0] a);
    return (a >= vcs_pkg::A_RAMP0) && (a < vcs_pkg::A_DITH_HALF);
  endfunction

  // Half period in cycles from the written step count
  assign dith_w = 20'(i_wdata) << vcs_pkg::DITH_UNIT_SH;

  // Writes; reset loads every parameter
  // defaults at reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ctrl_r  <= vcs_pkg::CTRL_RST;
      pgain_r <= vcs_pkg::GAIN_RST;
      ngain_r <= vcs_pkg::GAIN_RST;
      pbias_r <= '0;
      nbias_r <= '0;
      thr_r   <= '0;
      off_r   <= '0;
      dhalf_r <= vcs_pkg::DITH_DEF_HALF;
      damp_r  <= vcs_pkg::DAMP_RST;
      fbref_r <= '0;
      for (int k = 0; k < 4; k++) ramp_r[k] <= vcs_pkg::RAMP_RST;
      for (int k = 0; k < vcs_pkg::LIN_N; k++) lin_r[k] <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        vcs_pkg::A_CTRL:     ctrl_r  <= i_wdata;
        vcs_pkg::A_POS_GAIN: pgain_r <= i_wdata;
        vcs_pkg::A_NEG_GAIN: ngain_r <= i_wdata;
        vcs_pkg::A_POS_BIAS: pbias_r <= i_wdata;
        vcs_pkg::A_NEG_BIAS: nbias_r <= i_wdata;
        vcs_pkg::A_THRESH:   thr_r   <= i_wdata;
        vcs_pkg::A_OFFSET:   off_r   <= i_wdata;
        vcs_pkg::A_DITH_AMP: damp_r  <= i_wdata;
        vcs_pkg::A_FB_REF:   fbref_r <= i_wdata;
        vcs_pkg::A_DITH_HALF: begin
          if (dith_w < vcs_pkg::DITH_MIN_HALF) dhalf_r <= vcs_pkg::DITH_MIN_HALF;
          else if (dith_w > vcs_pkg::DITH_MAX_HALF) dhalf_r <= vcs_pkg::DITH_MAX_HALF;
          else dhalf_r <= dith_w;
        end
        // Addresses past the knee table are ignored, not aliased
        default: begin
          if (is_lin(i_addr)) lin_r[i_addr[2:0]] <= i_wdata;
          else if (is_ramp(i_addr))
            ramp_r[2'(i_addr - vcs_pkg::A_RAMP0)] <= i_wdata;
        end
      endcase
    end
  end

  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        vcs_pkg::A_CTRL:      o_rdata <= ctrl_r;
        vcs_pkg::A_POS_GAIN:  o_rdata <= pgain_r;
        vcs_pkg::A_NEG_GAIN:  o_rdata <= ngain_r;
        vcs_pkg::A_POS_BIAS:  o_rdata <= pbias_r;
        vcs_pkg::A_NEG_BIAS:  o_rdata <= nbias_r;
        vcs_pkg::A_THRESH:    o_rdata <= thr_r;
        vcs_pkg::A_OFFSET:    o_rdata <= off_r;
        vcs_pkg::A_DITH_HALF: o_rdata <= 16'(dhalf_r >> vcs_pkg::DITH_UNIT_SH);
        vcs_pkg::A_DITH_AMP:  o_rdata <= damp_r;
        vcs_pkg::A_FB_REF:    o_rdata <= fbref_r;
        vcs_pkg::A_STATUS:    o_rdata <= {13'h0000, ready_r, en_s, fault_r};
        vcs_pkg::A_CMD:       o_rdata <= cmd_r;
        default: begin
          if (is_lin(i_addr)) o_rdata <= lin_r[i_addr[2:0]];
          else if (is_ramp(i_addr))
            o_rdata <= ramp_r[2'(i_addr - vcs_pkg::A_RAMP0)];
          else o_rdata <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, first stage read only by second
  logic [3:0] sy1_r, sy2_r;
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= {i_loop_low, i_coil_open, i_coil_short, i_enable};
      sy2_r <= sy1_r;
    end
  end
  assign en_s = sy2_r[0];

  logic fault_now;
  assign fault_now = sy2_r[1] | sy2_r[2] |
                     (ctrl_r[vcs_pkg::C_LOOP] & ctrl_r[vcs_pkg::C_BRK_EN] & sy2_r[3]);
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      fault_r   <= 1'b0;
      o_fault_b <= 1'b1;
    end else begin
      fault_r   <= fault_now;
      o_fault_b <= ~fault_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up hold and sample tick
  logic [31:0] up_cnt_r;
  logic [15:0] smp_cnt_r;
  logic        tick;
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      up_cnt_r <= '0;
      ready_r  <= 1'b0;
    end else if (!ready_r) begin
      up_cnt_r <= up_cnt_r + 32'h0000_0001;
      ready_r  <= (up_cnt_r >= 32'(STARTUP_CYCLES - 1));
    end
  end
  assign tick = (smp_cnt_r == 16'(vcs_pkg::SAMPLE_CYC - 1));
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || tick) smp_cnt_r <= '0;
    else smp_cnt_r <= smp_cnt_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processing chain; ramp steps every sample tick, dither and output registers every clock
  // source select
  logic signed [15:0] ref_s;
  assign ref_s = ctrl_r[vcs_pkg::C_SRC] ? fbref_r : i_analog_ref;

  function automatic logic signed [16:0] sat17(input logic signed [33:0] v);
    if (v > 34'sd32767) return 17'sd32767;
    if (v < -34'sd32767) return -17'sd32767;
    return v[16:0];
  endfunction

  logic signed [16:0] mag, biased, scaled, lin_v;
  logic               neg;
  logic signed [33:0] prod;
  always_comb begin
    neg  = ref_s[15];
    mag  = neg ? -17'(ref_s) : 17'(ref_s);
    if (mag > $signed({1'b0, thr_r}))
      biased = mag + $signed({1'b0, neg ? nbias_r : pbias_r});
    else
      biased = mag;
    prod   = biased * $signed({18'h0_0000, neg ? ngain_r : pgain_r});
    scaled = sat17(prod >>> vcs_pkg::GAIN_SH);
    if (ctrl_r[vcs_pkg::C_LIN_EN])
      lin_v = $signed({1'b0, lin_r[scaled[14:12]]}) +
              $signed({5'h00, scaled[11:0]});
    else
      lin_v = scaled;
    if (neg) lin_v = -lin_v;
    lin_v = sat17(34'(lin_v) + 34'($signed(off_r)));
  end

  logic signed [16:0] ramp_r_v;
  logic [15:0]        rate;
  logic               up;
  always_comb begin
    up = (lin_v > ramp_r_v);
    unique case (vcs_pkg::vcs_ramp_t'(ctrl_r[vcs_pkg::C_RMP_LO +: 2]))
      vcs_pkg::VCS_RAMP_OFF:  rate = ramp_r[0];
      vcs_pkg::VCS_RAMP_ONE:  rate = ramp_r[0];
      vcs_pkg::VCS_RAMP_TWO:  rate = up ? ramp_r[0] : ramp_r[1];
      vcs_pkg::VCS_RAMP_FOUR: rate = ramp_r[{ramp_r_v[16], ~up}];
    endcase
  end
  logic ramp_on;
  assign ramp_on = (ctrl_r[vcs_pkg::C_RMP_LO +: 2] != 2'b00);
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) ramp_r_v <= '0;
    else if (tick) begin
      if (!ramp_on) ramp_r_v <= lin_v;
      else if (up)
        ramp_r_v <= (lin_v - ramp_r_v > $signed({1'b0, rate})) ?
                    17'(ramp_r_v + $signed({1'b0, rate})) : lin_v;
      else
        ramp_r_v <= (ramp_r_v - lin_v > $signed({1'b0, rate})) ?
                    17'(ramp_r_v - $signed({1'b0, rate})) : lin_v;
    end
  end

  logic [19:0] dcnt_r;
  logic        dph_r;
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      dcnt_r <= '0;
      dph_r  <= 1'b0;
    end else if (dcnt_r >= dhalf_r - 20'h0_0001 || dcnt_r >= vcs_pkg::DITH_MAX_HALF) begin
      dcnt_r <= '0;
      dph_r  <= ~dph_r;
    end else dcnt_r <= dcnt_r + 20'h0_0001;
  end

  logic signed [16:0] with_d;
  assign with_d = sat17(34'(ramp_r_v) + (dph_r ? 34'($signed({1'b0, damp_r}))
                                               : -34'($signed({1'b0, damp_r}))));
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cmd_r         <= '0;
      o_current_cmd <= '0;
    end else begin
      cmd_r         <= (en_s && ready_r) ? with_d[15:0] : 16'h0000;
      o_current_cmd <= (en_s && ready_r) ? with_d[15:0] : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_enable_gate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !en_s |=> o_current_cmd == 16'h0000) else $error("current not off while disabled");
  a_fault_pin: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    fault_now |=> !o_fault_b) else $error("fault pin not low");
  a_fault_clear: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !fault_now |=> o_fault_b) else $error("fault pin low without fault");
  a_coil_short: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(sy2_r[1]) |=> !o_fault_b) else $error("short not reported");
  a_startup_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !ready_r |=> o_current_cmd == 16'h0000) else $error("current during start-up");
  a_ramp_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !tick |=> $stable(ramp_r_v)) else $error("ramp moved between ticks");
  a_ramp_step: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    tick && ramp_on && up |=> ramp_r_v > $past(ramp_r_v)) else $error("ramp did not rise");
  a_no_ramp: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    tick && !ramp_on |=> ramp_r_v == $past(lin_v)) else $error("ramp off not direct");
  c_fault: cover property (@(posedge i_clock) disable iff (!i_rst_b) !o_fault_b);
  c_run: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    ready_r && en_s && o_current_cmd != 16'h0000);
  c_ramp: cover property (@(posedge i_clock) disable iff (!i_rst_b) tick && ramp_on && !up);

endmodule // vcs_shaper
`default_nettype wire

// [verification/vcs_mcu_model.sv]
/*
  Machine control unit model: drives the analog reference and the enable pin.
  Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module vcs_mcu_model (
  input  wire logic        i_clock,
  output logic      [15:0] o_analog_ref,
  output logic             o_enable
);
  // Driver disabled and reference at zero until told otherwise
  initial begin
    o_analog_ref = 16'h0000;
    o_enable     = 1'b0;
  end

  // Changes land just after an edge, never on it
  task automatic set_ref(input logic [15:0] v);
    @(posedge i_clock);
    o_analog_ref <= v;
  endtask

  task automatic set_enable(input logic v);
    @(posedge i_clock);
    o_enable <= v;
  endtask
endmodule // vcs_mcu_model

`default_nettype wire

// [verification/vcs_tb.sv]
/*
  Self-checking bench for the setpoint shaper: register port, faults,
  bias, gain, offset, source select, enable gating and ramps.
  Assumes a short start-up count and dither amplitude written to zero.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module testbench;
  localparam int unsigned TICK = vcs_pkg::SAMPLE_CYC + 5;
  logic        i_clock;
  logic        i_rst_b;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_coil_short;
  logic        i_coil_open;
  logic        i_loop_low;
  logic [15:0] o_rdata;
  logic [15:0] o_current_cmd;
  logic        o_fault_b;
  logic [15:0] ref_w;
  logic        en_w;
  logic [15:0] prev;
  int          errors;
  int          n_checks;

  vcs_mcu_model mcu (.i_clock(i_clock), .o_analog_ref(ref_w), .o_enable(en_w));
  vcs_shaper #(.STARTUP_CYCLES(50)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_analog_ref(ref_w),
    .i_enable(en_w), .i_coil_short(i_coil_short), .i_coil_open(i_coil_open),
    .i_loop_low(i_loop_low), .o_current_cmd(o_current_cmd), .o_fault_b(o_fault_b));

  // Free-running 100 MHz clock
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One idle cycle between strobes keeps each signal assigned once a step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic settle();
    repeat (TICK) @(posedge i_clock);
    #1;
  endtask

  // Bounded wait for the next ramp step
  // Sampled 1 ns after each edge so the command has settled
  task automatic ramp_step(input logic [15:0] delta);
    #1 prev = o_current_cmd;
    for (int k = 0; k < TICK && o_current_cmd === prev; k++) begin
      @(posedge i_clock);
      #1;
    end
    chk(o_current_cmd, prev + delta);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(o_current_cmd, 16'h0000);
    rd(vcs_pkg::A_CTRL, vcs_pkg::CTRL_RST);
    rd(vcs_pkg::A_POS_GAIN, vcs_pkg::GAIN_RST);
    rd(vcs_pkg::A_RAMP0, vcs_pkg::RAMP_RST);
    rd(vcs_pkg::A_DITH_AMP, vcs_pkg::DAMP_RST);
    rd(5'h1F, 16'h0000);
    rd(vcs_pkg::A_DITH_HALF, 16'(vcs_pkg::DITH_DEF_HALF >> vcs_pkg::DITH_UNIT_SH));
    wr(vcs_pkg::A_DITH_HALF, 16'h0001);
    rd(vcs_pkg::A_DITH_HALF, 16'(vcs_pkg::DITH_MIN_HALF >> vcs_pkg::DITH_UNIT_SH));
    wr(vcs_pkg::A_DITH_HALF, 16'hFFFF);
    rd(vcs_pkg::A_DITH_HALF, 16'(vcs_pkg::DITH_MAX_HALF >> vcs_pkg::DITH_UNIT_SH));
    $display("test reset done");
  endtask

  // Each pin alone faults, with the driver disabled throughout
  task automatic t_fault();
    for (int p = 0; p < 3; p++) begin
      @(posedge i_clock);
      i_coil_short <= (p == 0);
      i_coil_open  <= (p == 1);
      i_loop_low   <= (p == 2);
      repeat (4) @(posedge i_clock);
      #1 chk({15'h0000, o_fault_b}, 16'h0000);
      @(posedge i_clock);
      i_coil_short <= 1'b0;
      i_coil_open  <= 1'b0;
      i_loop_low   <= 1'b0;
      repeat (4) @(posedge i_clock);
      #1 chk({15'h0000, o_fault_b}, 16'h0001);
    end
    $display("test fault done");
  endtask

  task automatic t_chain();
    wr(vcs_pkg::A_DITH_AMP, 16'h0000);
    wr(vcs_pkg::A_CTRL, 16'h0000);
    wr(vcs_pkg::A_THRESH, 16'h0010);
    wr(vcs_pkg::A_POS_BIAS, 16'h0100);
    wr(vcs_pkg::A_NEG_BIAS, 16'h0200);
    wr(vcs_pkg::A_OFFSET, 16'h0040);
    wr(vcs_pkg::A_NEG_GAIN, 16'h0800);
    mcu.set_enable(1'b1);
    mcu.set_ref(16'h0008);
    settle();
    chk(o_current_cmd, 16'h0048);
    mcu.set_ref(16'h0400);
    settle();
    chk(o_current_cmd, 16'h0540);
    mcu.set_ref(16'hFC00);
    settle();
    chk(o_current_cmd, 16'hFD40);
    mcu.set_enable(1'b0);
    repeat (4) @(posedge i_clock);
    #1 chk(o_current_cmd, 16'h0000);
    mcu.set_enable(1'b1);
    wr(vcs_pkg::A_THRESH, 16'h0000);
    wr(vcs_pkg::A_FB_REF, 16'h0200);
    wr(vcs_pkg::A_CTRL, 16'h0001);
    settle();
    chk(o_current_cmd, 16'h0340);
    $display("test chain done");
  endtask

  task automatic t_ramp();
    // Fieldbus source, one rate
    wr(vcs_pkg::A_CTRL, 16'h0009);
    wr(vcs_pkg::A_FB_REF, 16'h0400);
    ramp_step(16'h0010);
    wr(vcs_pkg::A_RAMP0 + 5'h01, 16'h0020);
    wr(vcs_pkg::A_CTRL, 16'h0011);
    wr(vcs_pkg::A_FB_REF, 16'h0000);
    ramp_step(16'hFFE0);
    // Jump below zero with ramp off, then fall at the negative-side rate
    wr(vcs_pkg::A_CTRL, 16'h0001);
    wr(vcs_pkg::A_FB_REF, 16'hFC00);
    settle();
    chk(o_current_cmd, 16'hFD40);
    wr(vcs_pkg::A_RAMP0 + 5'h03, 16'h0030);
    wr(vcs_pkg::A_CTRL, 16'h0019);
    wr(vcs_pkg::A_FB_REF, 16'hF000);
    ramp_step(16'hFFD0);
    $display("test ramp done");
  endtask

  // Reset in mid-run with the driver enabled: current held through start-up
  task automatic t_midreset();
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 chk(o_current_cmd, 16'h0000);
    chk({15'h0000, o_fault_b}, 16'h0001);
    @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clock);
    #1 chk(o_current_cmd, 16'h0000);
    rd(vcs_pkg::A_CTRL, vcs_pkg::CTRL_RST);
    repeat (30) @(posedge i_clock);
    #1 chk(o_current_cmd, 16'h0000);
    repeat (26) @(posedge i_clock);
    #1 chk(o_current_cmd, 16'h0000 - vcs_pkg::DAMP_RST);
    rd(vcs_pkg::A_STATUS, 16'h0006);
    rd(vcs_pkg::A_CMD, 16'h0000 - vcs_pkg::DAMP_RST);
    $display("test midreset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial begin
    errors = 0;
    n_checks = 0;
    i_rst_b = 1'b0;
    i_addr = 5'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_loop_low = 1'b0;
    i_coil_open = 1'b0;
    i_coil_short = 1'b0;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    #1;
    t_reset();
    t_fault();
    t_chain();
    t_ramp();
    t_midreset();
    results();
  end

  // Eight sample ticks plus margin should finish well inside this span
  initial begin
    #950_000;
    errors++;
    results();
  end
endmodule // testbench

`default_nettype wire
